/* File: rtl/dpt_ctrl.sv */
// host-side controller enforcing ddr4 power-down, termination and write-levelling spacing
//
// How it works
// - after a mode set through the command register (not the levelling one), wait the mode-update delay before lowering clock enable
// - after a read, wait read latency plus 4 plus 1 before power-down
// - after a write, wait write latency plus 4 (or 2) plus recovery
// - after write with auto precharge, wait the same as after a write plus one more clock
// - termination with burst-8 write stays high 6 or 7 clocks by preamble
// - other termination pulses stay high 4 or 5 clocks by preamble
// - first strobe rising edge no sooner than 40 clocks after levelling set
// - strobe pair driven no sooner than 25 clocks after levelling set
// - gear-down mode is never used
// - with parity on and dll off, refresh time grows by parity latency
// - nanosecond figures become clocks by division and rounding
// - command-address latency is the larger of 3 clocks and 3.748 ns
// - below 1600 MT/s the slowest grade's clock counts apply
// - software should spread accesses over rows; no logic needed here
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module dpt_ctrl
   import dpt_pkg::*;
#(
   parameter int MODE_UPDATE_CK = 24,   // mode_update_delay in clocks
   parameter int REFRESH_CK     = 70,
   parameter int W              = DPT_CW
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [3:0]   addr,
   input  wire logic [31:0]  wdata,
   input  wire logic         wr,
   input  wire logic         rd,
   output      logic [31:0]  rdata,
   input  wire logic         wlvl_fb,
   output      dpt_pins_t    pins
);
   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   initial begin
      if (MODE_UPDATE_CK < 1 || MODE_UPDATE_CK >= (1 << W)) $error("dpt_ctrl: MODE_UPDATE_CK out of range");
      if (REFRESH_CK < 1 || REFRESH_CK >= (1 << (W - 1))) $error("dpt_ctrl: REFRESH_CK out of range");
      if (W < 7) $error("dpt_ctrl: W too small for levelling waits");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] rdata;
      dpt_pins_t   pins;
      logic [5:0]  write_cas_latency;
      logic [5:0]  al;
      logic [3:0]  pl;
      logic [5:0]  wrec;
      logic        bc4f;
      logic        pre2;
      logic        dlloff;
      logic        paren;
      logic [W-1:0] term_cnt;
      logic [W-1:0] wl_cnt;
      dpt_wl_t     wl_st;
      logic        wl_res;
      logic        refused;   // sticky: a command was refused since the last status read
   } dpt_st_t;

   dpt_st_t st_q;
   dpt_st_t st_d;

   function automatic logic [W-1:0] ck(input int v);
      return v[W-1:0];
   endfunction : ck

   // ---------------------------------------------------------------
   // derived latencies
   // ---------------------------------------------------------------
   logic [W-1:0] wl_tot;
   logic [W-1:0] rl_tot;
   logic [W-1:0] burst_tail;
   always_comb begin
      wl_tot     = ck(int'(st_q.write_cas_latency) + int'(st_q.al) + int'(st_q.pl));
      rl_tot     = wl_tot;  // read latency tracks write latency plus the same additive part
      burst_tail = st_q.bc4f ? ck(DPT_WR_BC4_EXTRA) : ck(DPT_WR_BL8_EXTRA);
   end

   // ---------------------------------------------------------------
   // per-constraint counters
   // ---------------------------------------------------------------
   logic         ld_mrs;
   logic         ld_rd;
   logic         ld_wr;
   logic         ld_ref;
   logic         busy_mrs;
   logic         busy_rd;
   logic         busy_wr;
   logic         busy_ref;
   logic [W-1:0] v_rd;
   logic [W-1:0] v_wr;
   logic [W-1:0] v_ref;
   logic         is_cmd;
   logic [2:0]   cmd;

   assign is_cmd = wr && addr == DPT_REG_CMD;
   assign cmd    = wdata[DPT_CMD_LSB +: 3];

   always_comb begin
      v_rd  = rl_tot + ck(DPT_RD_EXTRA + DPT_RD_ONE);
      v_wr  = wl_tot + burst_tail + ck(int'(st_q.wrec));
      if (cmd == DPT_CMD_WRA) begin
         v_wr = v_wr + ck(DPT_WRA_ONE);
      end
      v_ref = ck(REFRESH_CK);
      if (st_q.paren && st_q.dlloff) begin
         v_ref = v_ref + ck(int'(st_q.pl));
      end
   end

   logic pd_block;
   assign pd_block = busy_mrs | busy_rd | busy_wr | busy_ref;

   assign ld_mrs = is_cmd && cmd == DPT_CMD_MRS && !pd_block;
   assign ld_rd  = is_cmd && cmd == DPT_CMD_RD && st_q.pins.cke;
   assign ld_wr  = is_cmd && (cmd == DPT_CMD_WR || cmd == DPT_CMD_WRA) && st_q.pins.cke;
   assign ld_ref = is_cmd && cmd == DPT_CMD_REF && st_q.pins.cke;

   dpt_gap_cnt #(.W(W)) u_mrs (
      .clk   (clk),
      .rst_b (rst_b),
      .load  (ld_mrs),
      .value (ck(MODE_UPDATE_CK)),
      .busy  (busy_mrs)
   );
   dpt_gap_cnt #(.W(W)) u_rd (
      .clk   (clk),
      .rst_b (rst_b),
      .load  (ld_rd),
      .value (v_rd),
      .busy  (busy_rd)
   );
   dpt_gap_cnt #(.W(W)) u_wr (
      .clk   (clk),
      .rst_b (rst_b),
      .load  (ld_wr),
      .value (v_wr),
      .busy  (busy_wr)
   );
   dpt_gap_cnt #(.W(W)) u_ref (
      .clk   (clk),
      .rst_b (rst_b),
      .load  (ld_ref),
      .value (v_ref),
      .busy  (busy_ref)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic [W-1:0] term_len;
   always_comb begin
      st_d = st_q;
      st_d.pins.cmd_vld = 1'b0;
      st_d.pins.cmd     = '0;
      st_d.rdata        = '0;
      term_len          = '0;

      // register writes
      if (wr) begin
         if (addr == DPT_REG_LAT) begin
            st_d.write_cas_latency = wdata[DPT_CWL_LSB +: 6];
            st_d.al  = wdata[DPT_AL_LSB +: 6];
            st_d.pl  = wdata[DPT_PL_LSB +: 4];
         end else if (addr == DPT_REG_CFG) begin
            st_d.wrec   = wdata[DPT_WR_LSB +: 6];
            st_d.bc4f   = wdata[DPT_BC4F_BIT];
            st_d.pre2   = wdata[DPT_PRE2_BIT];
            st_d.dlloff = wdata[DPT_DLLOFF_BIT];
            st_d.paren  = wdata[DPT_PAREN_BIT];
         end else if (addr == DPT_REG_CMD) begin
            if (cmd == DPT_CMD_PDE) begin
               if (pd_block || !st_q.pins.cke) begin
                  st_d.refused = 1'b1;
               end else begin
                  st_d.pins.cke     = 1'b0;
                  st_d.pins.cmd     = cmd;
                  st_d.pins.cmd_vld = 1'b1;
               end
            end else if (cmd == DPT_CMD_PDX) begin
               st_d.pins.cke     = 1'b1;
               st_d.pins.cmd     = cmd;
               st_d.pins.cmd_vld = 1'b1;
            end else if (ld_mrs || ld_rd || ld_wr || ld_ref) begin
               st_d.pins.cmd     = cmd;
               st_d.pins.cmd_vld = 1'b1;
            end else begin
               st_d.refused = 1'b1;
            end
         end else if (addr == DPT_REG_TERM) begin
            if (wdata[DPT_TWR_BIT] && !wdata[DPT_TBC4_BIT]) begin
               term_len = st_q.pre2 ? ck(DPT_TERM_BL8_2CK) : ck(DPT_TERM_BL8_1CK);
            end else begin
               term_len = st_q.pre2 ? ck(DPT_TERM_BC4_2CK) : ck(DPT_TERM_BC4_1CK);
            end
            if (term_len > st_q.term_cnt) begin
               st_d.term_cnt = term_len;
            end
         end else if (addr == DPT_REG_WLVL) begin
            if (wdata[0] && st_q.wl_st == DPT_WL_IDLE) begin
               st_d.wl_st        = DPT_WL_WAIT;                             // levelling mode programmed
               st_d.wl_cnt       = '0;
               st_d.pins.cmd     = DPT_CMD_MRS;
               st_d.pins.cmd_vld = 1'b1;
            end else if (!wdata[0]) begin
               st_d.wl_st          = DPT_WL_IDLE;
               st_d.pins.strobe_oe = 1'b0;
               st_d.pins.strobe    = 1'b0;
            end
         end
      end

      // termination pulse width
      if (st_d.term_cnt != '0 && !(wr && addr == DPT_REG_TERM && term_len > st_q.term_cnt)) begin
         st_d.term_cnt = st_q.term_cnt - 1'b1;
      end
      st_d.pins.term = (st_d.term_cnt != '0);

      // ---------------------------------------------------------------
      // write levelling sequence
      // ---------------------------------------------------------------
      case (st_q.wl_st)
         DPT_WL_IDLE: begin
         end
         DPT_WL_WAIT: begin
            st_d.wl_cnt = st_q.wl_cnt + 1'b1;
            if (st_q.wl_cnt >= ck(DPT_WLVL_DRIVE - 1)) begin
               st_d.pins.strobe_oe = 1'b1;
            end
            if (st_q.wl_cnt >= ck(DPT_WLVL_FIRST - 1)) begin
               st_d.pins.strobe = 1'b1;
               st_d.wl_cnt      = '0;
               st_d.wl_st       = DPT_WL_PULSE;
            end
         end
         DPT_WL_PULSE: begin
            st_d.pins.strobe = 1'b0;
            st_d.wl_st       = DPT_WL_SAMPLE;
         end
         DPT_WL_SAMPLE: begin
            // allow the feedback delay plus one before sampling
            st_d.wl_cnt = st_q.wl_cnt + 1'b1;
            if (st_q.wl_cnt >= ck(DPT_WLVL_FB_CK)) begin
               st_d.wl_res = wlvl_fb;
               st_d.wl_cnt = '0;
               st_d.wl_st  = DPT_WL_IDLE;
            end
         end
         default: begin
            st_d.wl_st = DPT_WL_IDLE;
         end
      endcase
      if (wr && addr == DPT_REG_WLVL && !wdata[0]) begin
         st_d.wl_st = DPT_WL_IDLE;
      end

      // register reads
      if (rd) begin
         if (addr == DPT_REG_STATUS) begin
            st_d.rdata = {16'h0000, 8'(DPT_CAL_CK), 1'b0, st_q.refused, st_q.wl_res,
                          st_q.wl_st != DPT_WL_IDLE, pd_block, st_q.pins.term, 1'b0, st_q.pins.cke};
            st_d.refused = 1'b0;
         end else if (addr == DPT_REG_LAT) begin
            st_d.rdata = {12'h000, st_q.pl, 2'b00, st_q.al, 2'b00, st_q.write_cas_latency};
         end else if (addr == DPT_REG_CFG) begin
            st_d.rdata = {20'h00000, st_q.paren, st_q.dlloff, st_q.pre2, st_q.bc4f, 2'b00, st_q.wrec};
         end else if (addr == DPT_REG_TERM) begin
            st_d.rdata = {24'h000000, 8'(wl_tot - ck(DPT_TERM_LAT_SUB))};
         end else begin
            st_d.rdata = '0;
         end
         // a refusal arriving with the read survives
         if (wr && addr == DPT_REG_CMD && st_d.pins.cmd_vld == 1'b0) begin
            st_d.refused = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q          <= '0;
         st_q.pins.cke <= 1'b1;
         st_q.wl_st    <= DPT_WL_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;
   assign pins  = st_q.pins;

endmodule : dpt_ctrl

/* File: rtl/dpt_gap_cnt.sv */
// down-counter that holds one pending minimum-spacing constraint
`timescale 1ns/1ps
module dpt_gap_cnt
   import dpt_pkg::*;
#(
   parameter int W = DPT_CW
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output      logic         busy
);
   initial begin
      if (W < 2) $error("dpt_gap_cnt: width too small");
   end

   typedef struct packed {
      logic [W-1:0] cnt;
   } dpt_gap_st_t;

   dpt_gap_st_t st_q;
   dpt_gap_st_t st_d;

   // a new load never shortens a longer wait already running
   always_comb begin
      st_d = st_q;
      if (st_q.cnt != '0) begin
         st_d.cnt = st_q.cnt - 1'b1;
      end
      if (load && value > st_d.cnt) begin
         st_d.cnt = value;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign busy = (st_q.cnt != '0);

endmodule : dpt_gap_cnt

/* File: rtl/dpt_pkg.sv */
// package: constants and carrier types for the ddr4 power-down / termination / levelling timing controller
package dpt_pkg;

   // ---------------------------------------------------------------
   // register map of the controller's own port
   // ---------------------------------------------------------------
   localparam logic [3:0] DPT_REG_CMD    = 4'h0;  // write: issue command
   localparam logic [3:0] DPT_REG_LAT    = 4'h1;  // latencies cwl/al/pl
   localparam logic [3:0] DPT_REG_CFG    = 4'h2;  // write recovery, mode bits
   localparam logic [3:0] DPT_REG_STATUS = 4'h3;  // read: state
   localparam logic [3:0] DPT_REG_TERM   = 4'h4;  // write: termination pulse request
   localparam logic [3:0] DPT_REG_WLVL   = 4'h5;  // write: levelling start / stop

   // ---------------------------------------------------------------
   // command codes written to DPT_REG_CMD[2:0]
   // ---------------------------------------------------------------
   localparam logic [2:0] DPT_CMD_MRS    = 3'h1;
   localparam logic [2:0] DPT_CMD_RD     = 3'h2;
   localparam logic [2:0] DPT_CMD_WR     = 3'h3;
   localparam logic [2:0] DPT_CMD_WRA    = 3'h4;
   localparam logic [2:0] DPT_CMD_REF    = 3'h5;
   localparam logic [2:0] DPT_CMD_PDE    = 3'h6;  // power-down entry
   localparam logic [2:0] DPT_CMD_PDX    = 3'h7;  // power-down exit

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int DPT_CMD_LSB   = 0;
   localparam int DPT_CWL_LSB   = 0;   // lat[5:0]
   localparam int DPT_AL_LSB    = 8;   // lat[13:8]
   localparam int DPT_PL_LSB    = 16;  // lat[19:16]
   localparam int DPT_WR_LSB    = 0;   // cfg[5:0]  write recovery in clocks
   localparam int DPT_BC4F_BIT  = 8;   // cfg: burst chop 4 fixed by mode register
   localparam int DPT_PRE2_BIT  = 9;   // cfg: two-clock write preamble
   localparam int DPT_DLLOFF_BIT = 10; // cfg: dll off
   localparam int DPT_PAREN_BIT = 11;  // cfg: ca parity enabled
   localparam int DPT_TWR_BIT   = 0;   // term: pulse accompanies a write
   localparam int DPT_TBC4_BIT  = 1;   // term: that write is burst chop 4

   // ---------------------------------------------------------------
   // timing figures in clocks and in nanoseconds
   // ---------------------------------------------------------------
   localparam int DPT_RD_EXTRA      = 4;   // read_to_powerdown_gap = rl + 4 + 1
   localparam int DPT_RD_ONE        = 1;
   localparam int DPT_WR_BL8_EXTRA  = 4;
   localparam int DPT_WR_BC4_EXTRA  = 2;
   localparam int DPT_WRA_ONE       = 1;
   localparam int DPT_TERM_BL8_1CK  = 6;   // term_high_time_long_burst
   localparam int DPT_TERM_BL8_2CK  = 7;
   localparam int DPT_TERM_BC4_1CK  = 4;   // term_high_time_short_burst
   localparam int DPT_TERM_BC4_2CK  = 5;
   localparam int DPT_WLVL_FIRST    = 40;  // wlvl_first_strobe_wait
   localparam int DPT_WLVL_DRIVE    = 25;  // wlvl_strobe_drive_wait
   localparam int DPT_TERM_LAT_SUB  = 2;   // direct term latency = wl - 2
   localparam int DPT_CAL_MIN_CK    = 3;
   localparam real DPT_CAL_MIN_NS   = 3.748;
   localparam real DPT_WLVL_FB_NS   = 9.5; // wlvl_feedback_delay, device side
   localparam real DPT_CLK_NS       = 5.0;
   localparam int DPT_WLVL_FB_CK    = int'(DPT_WLVL_FB_NS / DPT_CLK_NS) < 1 ? 1
                                      : int'($floor(DPT_WLVL_FB_NS / DPT_CLK_NS));
   localparam int DPT_CAL_NS_CK     = int'($ceil(DPT_CAL_MIN_NS / DPT_CLK_NS));
   localparam int DPT_CAL_CK        = DPT_CAL_NS_CK > DPT_CAL_MIN_CK ? DPT_CAL_NS_CK : DPT_CAL_MIN_CK;

   localparam int DPT_CW = 8;  // width of every down-counter

   // ---------------------------------------------------------------
   // carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } dpt_bus_req_t;

   typedef struct packed {
      logic       cke;         // clock enable, low = power-down
      logic [2:0] cmd;         // command presented on the command pins, one-cycle
      logic       cmd_vld;
      logic       term;        // termination control
      logic       strobe_oe;   // data strobe pair driven
      logic       strobe;      // strobe level (rising edge is a levelling pulse)
   } dpt_pins_t;

   typedef enum logic [1:0] {
      DPT_WL_IDLE,
      DPT_WL_WAIT,
      DPT_WL_PULSE,
      DPT_WL_SAMPLE
   } dpt_wl_t;

endpackage : dpt_pkg

/* File: test/dpt_ctrl_properties.sv */
// checker: spacing and pulse-width assertions on the controller's ports
`timescale 1ns/1ps
module dpt_ctrl_properties
   import dpt_pkg::*;
#(
   parameter int MODE_UPDATE_CK = 24,
   parameter int REFRESH_CK     = 70,
   parameter int W              = DPT_CW
) (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [3:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        wlvl_fb,
   input wire dpt_pins_t   pins
);
   // ------------------------------------------------------------
   // helper state
   // ------------------------------------------------------------
   logic [7:0]  since_q [8];  // cycles since each command code, saturating so old commands never fire
   logic [7:0]  tlen_q;
   logic [31:0] lat_q;
   logic [31:0] cfg_q;
   logic [1:0]  term_q;
   logic [7:0]  wl;
   logic [7:0]  wr_gap;
   logic [7:0]  t_req;
   assign wl     = 8'(lat_q[5:0]) + 8'(lat_q[13:8]) + 8'(lat_q[19:16]);
   assign wr_gap = wl + 8'(cfg_q[5:0]) + (cfg_q[DPT_BC4F_BIT] ? 8'(DPT_WR_BC4_EXTRA) : 8'(DPT_WR_BL8_EXTRA));
   assign t_req  = (term_q[DPT_TWR_BIT] && !term_q[DPT_TBC4_BIT])
                 ? (cfg_q[DPT_PRE2_BIT] ? 8'(DPT_TERM_BL8_2CK) : 8'(DPT_TERM_BL8_1CK))
                 : (cfg_q[DPT_PRE2_BIT] ? 8'(DPT_TERM_BC4_2CK) : 8'(DPT_TERM_BC4_1CK));
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 8; i++) begin
            since_q[i] <= 8'hff;
         end
         tlen_q <= 8'h00;
         lat_q  <= 32'h0;
         cfg_q  <= 32'h0;
         term_q <= 2'h0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (pins.cmd_vld && pins.cmd == 3'(i)) begin
               since_q[i] <= 8'h01;
            end else if (since_q[i] != 8'hff) begin
               since_q[i] <= since_q[i] + 8'h01;
            end
         end
         tlen_q <= pins.term ? tlen_q + 8'h01 : 8'h00;
         if (wr && addr == DPT_REG_LAT) begin
            lat_q <= wdata;
         end
         if (wr && addr == DPT_REG_CFG) begin
            cfg_q <= wdata;
         end
         if (wr && addr == DPT_REG_TERM) begin
            term_q <= wdata[1:0];
         end
      end
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   property p_pde_only;
      $fell(pins.cke) |-> pins.cmd_vld && pins.cmd == DPT_CMD_PDE;
   endproperty
   a_pde_only: assert property (p_pde_only) else $error("cke fell without entry");
   property p_mrs_gap;
      $fell(pins.cke) |-> since_q[DPT_CMD_MRS] >= 8'(MODE_UPDATE_CK);
   endproperty
   a_mrs_gap: assert property (p_mrs_gap) else $error("mode set too close");
   property p_rd_gap;
      $fell(pins.cke) |-> since_q[DPT_CMD_RD] >= wl + 8'h05;
   endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("read too close");
   property p_wr_gap;
      $fell(pins.cke) |-> since_q[DPT_CMD_WR] >= wr_gap;
   endproperty
   a_wr_gap: assert property (p_wr_gap) else $error("write too close");
   property p_wra_gap;
      $fell(pins.cke) |-> since_q[DPT_CMD_WRA] >= wr_gap + 8'h01;
   endproperty
   a_wra_gap: assert property (p_wra_gap) else $error("write autopre too close");
   property p_ref_gap;
      $fell(pins.cke) |-> since_q[DPT_CMD_REF] >= 8'(REFRESH_CK)
         + ((cfg_q[DPT_PAREN_BIT] && cfg_q[DPT_DLLOFF_BIT]) ? 8'(lat_q[19:16]) : 8'h00);
   endproperty
   a_ref_gap: assert property (p_ref_gap) else $error("refresh too close");
   property p_term_len;
      $fell(pins.term) |-> tlen_q >= t_req;
   endproperty
   a_term_len: assert property (p_term_len) else $error("term pulse short");
   property p_strobe_first;
      $rose(pins.strobe) |-> pins.strobe_oe && since_q[DPT_CMD_MRS] >= 8'(DPT_WLVL_FIRST);
   endproperty
   a_strobe_first: assert property (p_strobe_first) else $error("strobe edge early");
   property p_strobe_drive;
      $rose(pins.strobe_oe) |-> since_q[DPT_CMD_MRS] >= 8'(DPT_WLVL_DRIVE);
   endproperty
   a_strobe_drive: assert property (p_strobe_drive) else $error("strobe driven early");
   c_pde: cover property ($fell(pins.cke));
   c_term: cover property ($fell(pins.term));
   c_strobe: cover property ($rose(pins.strobe));
endmodule : dpt_ctrl_properties

bind dpt_ctrl dpt_ctrl_properties #(.MODE_UPDATE_CK(MODE_UPDATE_CK), .REFRESH_CK(REFRESH_CK), .W(W))
   dpt_ctrl_properties_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                          .rdata(rdata), .wlvl_fb(wlvl_fb), .pins(pins));

/* File: test/dpt_dev_model.sv */
// device model: levelling feedback, termination latency and internal write start
`timescale 1ns/1ps
module dpt_dev_model
   import dpt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire dpt_pins_t  pins,
   input  wire logic [7:0] wl,
   input  wire logic       bc4f,
   input  wire logic       level,
   output      logic       wlvl_fb,
   output      logic       term_rtt,
   output      logic       write_start
);
   // ------------------------------------------------------------
   // behaviour
   // ------------------------------------------------------------
   logic [63:0] hist_q;
   logic [2:0]  hold_q;
   logic [7:0]  wcnt_q;
   assign term_rtt    = hist_q[6'(wl - 8'h02)];
   assign write_start = (wcnt_q == 8'h01);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hist_q  <= 64'h0;
         hold_q  <= 3'h0;
         wcnt_q  <= 8'h00;
         wlvl_fb <= 1'b0;
      end else begin
         hist_q <= {hist_q[62:0], pins.term};
         hold_q <= pins.strobe ? 3'h5 : hold_q - 3'(hold_q != 3'h0);
         // outside the feedback window the line toggles, so a stale level is never read as a result
         wlvl_fb <= (pins.strobe || hold_q != 3'h0) ? level : ~wlvl_fb;
         if (pins.cmd_vld && (pins.cmd == DPT_CMD_WR || pins.cmd == DPT_CMD_WRA)) begin
            wcnt_q <= wl + (bc4f ? 8'h02 : 8'h04);
         end else if (wcnt_q != 8'h00) begin
            wcnt_q <= wcnt_q - 8'h01;
         end
      end
   end
endmodule : dpt_dev_model

/* File: test/testbench.sv */
// testbench: register-port tests of the power-down, termination and levelling controller
`timescale 1ns/1ps
module testbench;
   import dpt_pkg::*;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   localparam int MUPD = 4;
   localparam int RFC  = 8;
   localparam int WLAT = 8;  // cwl 5 + al 1 + pl 2
   logic        clk;
   logic        rst_b;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        wlvl_fb;
   dpt_pins_t   pins;
   logic        bc4f;
   logic        level;
   logic [31:0] rv;
   int          err_count = 0;
   int          checks = 0;
   int          cyc = 0;
   dpt_ctrl #(.MODE_UPDATE_CK(MUPD), .REFRESH_CK(RFC), .W(DPT_CW)) dpt_ctrl_i (.clk(clk), .rst_b(rst_b),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wlvl_fb(wlvl_fb), .pins(pins));
   dpt_dev_model dpt_dev_model_i (.clk(clk), .rst_b(rst_b), .pins(pins), .wl(8'(WLAT)), .bc4f(bc4f),
      .level(level), .wlvl_fb(wlvl_fb), .term_rtt(), .write_start());
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      #1;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      rv = rdata;
   endtask : bus_rd
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   // power-down is polled every two cycles, so entry lands within three cycles of the minimum
   task automatic gap_test(input logic [2:0] c, input int gap);
      int t0;
      int n;
      bus_wr(DPT_REG_CMD, 32'(c));
      t0 = cyc;
      n = 0;
      while (pins.cke !== 1'b0 && n < 100) begin
         bus_wr(DPT_REG_CMD, 32'(DPT_CMD_PDE));
         n++;
      end
      check("gap min", 32'((cyc - t0) >= gap), 32'h1);
      check("gap max", 32'((cyc - t0) <= gap + 3), 32'h1);
      bus_rd(DPT_REG_STATUS);
      check("early entry refused", 32'(rv[6]), 32'h1);
      bus_wr(DPT_REG_CMD, 32'(c));
      bus_rd(DPT_REG_STATUS);
      check("status cke", 32'(rv[0]), 32'h0);
      check("cmd in power-down", 32'(rv[6]), 32'(c != DPT_CMD_MRS));
      bus_wr(DPT_REG_CMD, 32'(DPT_CMD_PDX));
      check("exit cke", 32'(pins.cke), 32'h1);
      $display("test gap for command %0d done", c);
   endtask : gap_test
   task automatic term_test(input logic pre2, input logic [1:0] tv, input int exp);
      int n;
      bus_wr(DPT_REG_CFG, 32'h3 | (32'(pre2) << DPT_PRE2_BIT));
      bus_wr(DPT_REG_TERM, 32'(tv));
      n = 0;
      while (pins.term === 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("term width", 32'(n), 32'(exp));
      $display("test term %0d %0d done", pre2, tv);
   endtask : term_test
   task automatic wlvl_test(input logic lvl);
      int n;
      level <= lvl;
      bus_wr(DPT_REG_WLVL, 32'h1);
      n = 0;
      while (pins.strobe_oe !== 1'b1 && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("drive wait", 32'(n >= 25 && n <= 27), 32'h1);
      while (pins.strobe !== 1'b1 && n < 80) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("first edge wait", 32'(n >= 40 && n <= 42), 32'h1);
      bus_rd(DPT_REG_STATUS);
      check("levelling active", 32'(rv[4]), 32'h1);
      repeat (2) @(posedge clk);
      bus_rd(DPT_REG_STATUS);
      check("levelling result", 32'(rv[5]), 32'(lvl));
      check("levelling done", 32'(rv[4]), 32'h0);
      bus_wr(DPT_REG_WLVL, 32'h0);
      $display("test levelling %0d done", lvl);
   endtask : wlvl_test
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      addr  = 4'h0;
      wdata = 32'h0;
      wr    = 1'b0;
      rd    = 1'b0;
      bc4f  = 1'b0;
      level = 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      bus_rd(DPT_REG_STATUS);
      check("reset cke", 32'(rv[0]), 32'h1);
      check("cal clocks", 32'(rv[15:8]), 32'h3);
      bus_wr(DPT_REG_LAT, 32'h0002_0105);
      bus_wr(DPT_REG_CFG, 32'h0000_0003);
      bus_rd(DPT_REG_TERM);
      check("term latency", rv, 32'(WLAT - 2));
      gap_test(DPT_CMD_MRS, MUPD);
      gap_test(DPT_CMD_RD, WLAT + 5);
      gap_test(DPT_CMD_WR, WLAT + 4 + 3);
      gap_test(DPT_CMD_WRA, WLAT + 4 + 3 + 1);
      bus_wr(DPT_REG_CFG, 32'h0000_0103);
      bc4f <= 1'b1;
      gap_test(DPT_CMD_WR, WLAT + 2 + 3);
      gap_test(DPT_CMD_WRA, WLAT + 2 + 3 + 1);
      bus_wr(DPT_REG_CFG, 32'h0000_0c03);
      bc4f <= 1'b0;
      gap_test(DPT_CMD_REF, RFC + 2);
      term_test(1'b0, 2'h1, 6);
      term_test(1'b1, 2'h1, 7);
      term_test(1'b0, 2'h0, 4);
      term_test(1'b1, 2'h0, 5);
      term_test(1'b0, 2'h3, 4);
      term_test(1'b1, 2'h3, 5);
      wlvl_test(1'b1);
      wlvl_test(1'b0);
      conclude();
   end
   // the tests take a few hundred cycles; twenty thousand means a hang
   initial begin
      #100000;
      err_count++;
      conclude();
   end
endmodule : testbench
